/* core/e1_alarm_params.svh */
`ifndef E1_ALARM_PARAMS_SVH
`define E1_ALARM_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_ALARM_STATUS 8'h06
`define IDX_EVENT_STATUS 8'h07
`define IDX_ALARM_MASK 8'h16
`define IDX_EVENT_MASK 8'h17
`define IDX_CONTROL 8'h40
`define MASK_RESET 8'h00
`define CONTROL_RESET 8'h00
// Control fields
`define CTL_CRC4_EN 0
`define CTL_SHORT_PERIOD 1
`define CTL_LONG_CL 2
`define CTL_PIN_EN 3
// Line framing in bits
`define MF_LAST 12'hfff
`define TS16_FIRST 8'h80
`define TS16_LAST 8'h87
`define DMA_BIT 8'h85
`define RRA_BIT 8'h02
`define UA_LAST 9'h1ff
`define CL_SHORT 12'h0ff
`define CL_LONG 12'h800
`define CL_WIN_LAST 8'hfe
`define CL_ONES 6'h20
// Timing
`define CLK_NS 100
`define TX_LOSS_NS 3900
`define TX_LOSS_CYC (`TX_LOSS_NS / `CLK_NS)
`define LINE_RATE_HZ 2048000
`define SEC_US 1000000
`define SHORT_US 62500
`endif

/* core/e1_alarm_pkg.sv */
package e1_alarm_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      SEL_NONE, SEL_ALARM, SEL_EVENT, SEL_AMASK, SEL_EMASK, SEL_CTL
   } reg_sel_t;
endpackage

/* core/e1_alarm_status.sv */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "e1_alarm_params.svh"
// How it works
// - All-ones signaling: under three zeros per multiframe
// - All-zeros signaling: timeslot 16 zero whole multiframe
// - Distant alarm: two multiframes same bit 6
// - Unframed ones: under three zeros per 512 bits
// - Remote alarm: bit 3 three times alike
// - Carrier loss after 255 or 2048 zeros
// - Carrier back: 32 ones within 255 bits
// - Receive CAS multiframe flag every multiframe
// - Receive align frame flag each align frame
// - Transmit multiframe flag every multiframe
// - Second tick, or 62.5 ms when selected
// - Transmit align frame flag each align frame
// - Transmit clock loss after 3.9 us still
// - Loss pin high when enabled and lost
// - CRC4 multiframe flag, free-running when disabled
// - Transmit slip flag on store slip
// - Alarm mask bits gate alarm interrupts
// - Event mask bits gate event interrupts
// - Long carrier select picks 2048 threshold
// - Signaling change sets both signaling flags
// - Sync loss flagged while unsynchronized
module e1_alarm_status
   import e1_alarm_pkg::*;
#(
   parameter int SEC_BITS = `LINE_RATE_HZ / 1000 * `SEC_US / 1000,
   parameter int SHORT_BITS = `LINE_RATE_HZ / 1000 * `SHORT_US / 1000
) (
   // System
   input wire logic clock,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive line pins
   input wire logic rxLineClock,
   input wire logic rxLineData,
   input wire logic rxMfStart,
   input wire logic rxCrcMfStart,
   input wire logic rxInSync,
   input wire logic rxSlip,
   // Transmit pins
   input wire logic txLineClock,
   input wire logic txMfStart,
   input wire logic txSlip,
   // Outputs
   output logic txClockLossPin,
   output logic irq
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int NP = 9;
   logic [NP-1:0] pinRaw, s0_q, s1_q, s2_q, lvl_q, stab, rise;
   assign pinRaw = {txSlip, txMfStart, txLineClock, rxSlip, rxInSync,
                    rxCrcMfStart, rxMfStart, rxLineData, rxLineClock};
   assign stab = (lvl_q & (s1_q ^ s2_q)) | (s2_q & ~(s1_q ^ s2_q));
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s0_q <= '0;
         s1_q <= '0;
         s2_q <= '0;
         lvl_q <= '0;
      end else begin
         s0_q <= pinRaw;
         s1_q <= s0_q;
         s2_q <= s1_q;
         lvl_q <= stab;
      end
   end
   assign rise = stab & ~lvl_q;
   logic rxBit, rxD, rxMf, rxCrcMf, syncLoss, rxSlipEv;
   logic txBit, txChg, txMf, txSlipEv;
   assign rxBit = rise[0];
   assign rxD = stab[1];
   assign rxMf = stab[2];
   assign rxCrcMf = stab[3];
   assign syncLoss = ~stab[4];
   assign rxSlipEv = rise[5];
   assign txBit = rise[6];
   assign txChg = stab[6] ^ lvl_q[6];
   assign txMf = stab[7];
   assign txSlipEv = rise[8];

   function automatic logic [1:0] sat3(input logic [1:0] v, input logic inc);
      sat3 = (inc && v != 2'h3) ? v + 2'h1 : v;
   endfunction

   // ------------------------------------------------------------
   // Registers seen by software
   // ------------------------------------------------------------
   byte_t alarm_q, event_q, amask_q, emask_q, ctl_q;
   logic crc4En, shortSel, longSel, pinEn;
   assign crc4En = ctl_q[`CTL_CRC4_EN];
   assign shortSel = ctl_q[`CTL_SHORT_PERIOD];
   assign longSel = ctl_q[`CTL_LONG_CL];
   assign pinEn = ctl_q[`CTL_PIN_EN];

   // ------------------------------------------------------------
   // Receive bit position
   // ------------------------------------------------------------
   logic [11:0] rxCnt_q, pos;
   logic [7:0] bitPos;
   logic [3:0] frm;
   logic mfEnd, ts16;
   assign pos = rxMf ? 12'h000 : rxCnt_q;
   assign bitPos = pos[7:0];
   assign frm = pos[11:8];
   assign mfEnd = pos == `MF_LAST;
   assign ts16 = bitPos >= `TS16_FIRST && bitPos <= `TS16_LAST;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) rxCnt_q <= '0;
      else if (rxBit) rxCnt_q <= pos + 12'h001;
   end

   // ------------------------------------------------------------
   // Signaling alarms
   // ------------------------------------------------------------
   logic [1:0] sigZero_q, zNext;
   logic sigOne_q, oNext, sigOnes_q, sigZeros_q, sigChg_q;
   byte_t ts16Sh_q, ts16Next;
   byte_t ts16Mem_q [16];
   logic memValid_q;
   assign zNext = sat3(sigZero_q, ts16 & ~rxD);
   assign oNext = sigOne_q | (ts16 & rxD);
   assign ts16Next = {ts16Sh_q[6:0], rxD};
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sigZero_q <= '0;
         sigOne_q <= 1'b0;
         sigOnes_q <= 1'b0;
         sigZeros_q <= 1'b0;
      end else if (rxBit) begin
         sigZero_q <= mfEnd ? 2'h0 : zNext;
         sigOne_q <= mfEnd ? 1'b0 : oNext;
         if (mfEnd) begin
            sigOnes_q <= zNext != 2'h3;
            sigZeros_q <= !oNext;
         end
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ts16Sh_q <= '0;
         memValid_q <= 1'b0;
         sigChg_q <= 1'b0;
         for (int i = 0; i < 16; i++) ts16Mem_q[i] <= '0;
      end else begin
         sigChg_q <= 1'b0;
         if (rxBit && ts16) ts16Sh_q <= ts16Next;
         if (rxBit && bitPos == `TS16_LAST) begin
            ts16Mem_q[frm] <= ts16Next;
            sigChg_q <= memValid_q && ts16Mem_q[frm] != ts16Next;
            if (frm == 4'hf) memValid_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Distant multiframe and remote alarms
   // ------------------------------------------------------------
   logic [1:0] dmaOne_q, dmaZero_q, rraOne_q, rraZero_q;
   logic dma_q, rra_q, dmaAt, rraAt;
   assign dmaAt = rxBit && frm == 4'h0 && bitPos == `DMA_BIT;
   assign rraAt = rxBit && frm[0] && bitPos == `RRA_BIT;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dmaOne_q <= '0;
         dmaZero_q <= '0;
         dma_q <= 1'b0;
      end else if (dmaAt) begin
         dmaOne_q <= rxD ? sat3(dmaOne_q, 1'b1) : 2'h0;
         dmaZero_q <= rxD ? 2'h0 : sat3(dmaZero_q, 1'b1);
         if (rxD && dmaOne_q != 2'h0) dma_q <= 1'b1;
         if (!rxD && dmaZero_q != 2'h0) dma_q <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rraOne_q <= '0;
         rraZero_q <= '0;
         rra_q <= 1'b0;
      end else if (rraAt) begin
         rraOne_q <= rxD ? sat3(rraOne_q, 1'b1) : 2'h0;
         rraZero_q <= rxD ? 2'h0 : sat3(rraZero_q, 1'b1);
         if (rxD && rraOne_q >= 2'h2) rra_q <= 1'b1;
         if (!rxD && rraZero_q >= 2'h2) rra_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Unframed all ones and carrier loss
   // ------------------------------------------------------------
   logic [8:0] uaCnt_q;
   logic [1:0] uaZero_q, uaNext;
   logic ua_q;
   assign uaNext = sat3(uaZero_q, ~rxD);
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         uaCnt_q <= '0;
         uaZero_q <= '0;
         ua_q <= 1'b0;
      end else if (rxBit) begin
         uaCnt_q <= uaCnt_q + 9'h001;
         uaZero_q <= uaCnt_q == `UA_LAST ? 2'h0 : uaNext;
         if (uaCnt_q == `UA_LAST) ua_q <= uaNext != 2'h3;
      end
   end
   logic [11:0] zeroRun_q, runNext, clLimit;
   logic [7:0] clWin_q;
   logic [5:0] clOnes_q, onesNext;
   logic cl_q;
   assign clLimit = longSel ? `CL_LONG : `CL_SHORT;
   assign runNext = rxD ? 12'h000 :
                    (zeroRun_q == clLimit ? zeroRun_q : zeroRun_q + 12'h001);
   assign onesNext = (rxD && clOnes_q != `CL_ONES) ? clOnes_q + 6'h01 : clOnes_q;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         zeroRun_q <= '0;
         clWin_q <= '0;
         clOnes_q <= '0;
         cl_q <= 1'b0;
      end else if (rxBit) begin
         zeroRun_q <= runNext;
         clWin_q <= clWin_q == `CL_WIN_LAST ? 8'h00 : clWin_q + 8'h01;
         clOnes_q <= clWin_q == `CL_WIN_LAST ? 6'h00 : onesNext;
         if (runNext == clLimit) cl_q <= 1'b1;
         else if (clWin_q == `CL_WIN_LAST && onesNext == `CL_ONES) cl_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Receive timing events
   // ------------------------------------------------------------
   logic [21:0] secCnt_q;
   logic [21:0] secLast;
   logic rmfEv, rafEv, secEv, rcmfEv;
   assign secLast = shortSel ? 22'(SHORT_BITS - 1) : 22'(SEC_BITS - 1);
   assign rmfEv = rxBit && pos == 12'h000;
   assign rafEv = rxBit && !frm[0] && bitPos == 8'h00;
   assign secEv = rxBit && secCnt_q >= secLast;
   assign rcmfEv = crc4En ? rxBit && rxCrcMf : rmfEv;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) secCnt_q <= '0;
      else if (secEv) secCnt_q <= '0;
      else if (rxBit) secCnt_q <= secCnt_q + 22'h000001;
   end

   // ------------------------------------------------------------
   // Transmit timing and clock loss
   // ------------------------------------------------------------
   logic [11:0] txCnt_q, txPos;
   logic [7:0] lossCnt_q;
   logic txLoss_q, tmfEv, tafEv;
   assign txPos = txMf ? 12'h000 : txCnt_q;
   assign tmfEv = txBit && txPos == 12'h000;
   assign tafEv = txBit && !txPos[8] && txPos[7:0] == 8'h00;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) txCnt_q <= '0;
      else if (txBit) txCnt_q <= txPos + 12'h001;
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lossCnt_q <= '0;
         txLoss_q <= 1'b0;
      end else if (txChg) begin
         lossCnt_q <= '0;
         txLoss_q <= 1'b0;
      end else if (lossCnt_q != 8'(`TX_LOSS_CYC)) begin
         lossCnt_q <= lossCnt_q + 8'h01;
      end else begin
         txLoss_q <= 1'b1;
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) txClockLossPin <= 1'b0;
      else txClockLossPin <= pinEn & txLoss_q;
   end

   // ------------------------------------------------------------
   // APB slave and status latches
   // ------------------------------------------------------------
   reg_sel_t sel;
   logic wrAcc;
   byte_t alarmSet, eventSet, alarmClr, eventClr;
   always_comb begin
      if (paddr[11:2] == {2'b00, `IDX_ALARM_STATUS}) sel = SEL_ALARM;
      else if (paddr[11:2] == {2'b00, `IDX_EVENT_STATUS}) sel = SEL_EVENT;
      else if (paddr[11:2] == {2'b00, `IDX_ALARM_MASK}) sel = SEL_AMASK;
      else if (paddr[11:2] == {2'b00, `IDX_EVENT_MASK}) sel = SEL_EMASK;
      else if (paddr[11:2] == {2'b00, `IDX_CONTROL}) sel = SEL_CTL;
      else sel = SEL_NONE;
   end
   assign wrAcc = psel & penable & pwrite;
   assign pready = penable;
   assign alarmSet = {sigOnes_q | sigChg_q, dma_q, sigZeros_q | sigChg_q, rxSlipEv,
                      ua_q, rra_q, cl_q, syncLoss};
   assign eventSet = {rmfEv, rafEv, tmfEv, secEv, tafEv, txLoss_q, rcmfEv,
                      txSlipEv};
   assign alarmClr = (wrAcc && sel == SEL_ALARM) ? pwdata[7:0] : 8'h00;
   assign eventClr = (wrAcc && sel == SEL_EVENT) ? pwdata[7:0] : 8'h00;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_q <= '0;
         event_q <= '0;
      end else begin
         alarm_q <= (alarm_q & ~alarmClr) | alarmSet;
         event_q <= (event_q & ~eventClr) | eventSet;
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         amask_q <= `MASK_RESET;
         emask_q <= `MASK_RESET;
         ctl_q <= `CONTROL_RESET;
      end else if (wrAcc) begin
         if (sel == SEL_AMASK) amask_q <= pwdata[7:0];
         if (sel == SEL_EMASK) emask_q <= pwdata[7:0];
         if (sel == SEL_CTL) ctl_q <= pwdata[7:0];
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= sel == SEL_NONE;
         case (sel)
            SEL_ALARM: prdata <= {24'h000000, alarm_q};
            SEL_EVENT: prdata <= {24'h000000, event_q};
            SEL_AMASK: prdata <= {24'h000000, amask_q};
            SEL_EMASK: prdata <= {24'h000000, emask_q};
            SEL_CTL: prdata <= {24'h000000, ctl_q};
            default: prdata <= '0;
         endcase
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) irq <= 1'b0;
      else irq <= |(alarm_q & amask_q) | |(event_q & emask_q);
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_sig_ones;
      rxBit && mfEnd && zNext != 2'h3 |=> sigOnes_q ##1 alarm_q[7];
   endproperty
   a_sig_ones: assert property (p_sig_ones) else $error("all ones missed");
   property p_sig_zeros;
      rxBit && mfEnd && oNext |=> !sigZeros_q;
   endproperty
   a_sig_zeros: assert property (p_sig_zeros) else $error("all zeros stuck");
   property p_dma;
      dmaAt && rxD && dmaOne_q == 2'h0 && !dma_q |=> !dma_q;
   endproperty
   a_dma: assert property (p_dma) else $error("distant alarm early");
   property p_rra;
      rraAt && rxD && rraOne_q == 2'h2 |=> rra_q;
   endproperty
   a_rra: assert property (p_rra) else $error("remote alarm missed");
   property p_cl;
      rxBit && !rxD && zeroRun_q == clLimit - 12'h001 |=> cl_q;
   endproperty
   a_cl: assert property (p_cl) else $error("carrier loss missed");
   sequence s_still;
      !txChg [*8];
   endsequence
   property p_tx_clock_loss;
      txChg ##1 s_still |-> !txLoss_q;
   endproperty
   a_tx_clock_loss: assert property (p_tx_clock_loss) else $error("clock loss early");
   property p_pin;
      txClockLossPin |-> $past(pinEn) && $past(txLoss_q);
   endproperty
   a_pin: assert property (p_pin) else $error("loss pin without cause");
   property p_irq;
      (|(event_q & emask_q)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missed");
   property p_set_wins;
      secEv && eventClr[4] |=> event_q[4];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule

/* tb/e1_line_model.sv */
`timescale 1ns/1ps
module e1_line_model (
   // System
   input wire logic clock,
   input wire logic sys_rst,
   // Pattern control
   input wire logic lineOnes,
   input wire logic txRun,
   // Line pins
   output logic rxLineClock,
   output logic rxLineData,
   output logic rxMfStart,
   output logic rxCrcMfStart,
   output logic txLineClock,
   output logic txMfStart
);
   logic [2:0] phase_q;
   logic [11:0] bit_q;

   // ------------------------------------------------------------
   // Bit timing: one bit per eight system cycles
   // ------------------------------------------------------------
   // Data and markers move on the rising edge, once every eighth cycle when phase_q is 7
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= 3'h0;
         bit_q <= 12'h000;
         rxLineData <= 1'b0;
      end else begin
         phase_q <= phase_q + 3'h1;
         if (phase_q == 3'h7) begin
            bit_q <= bit_q + 12'h001;
            rxLineData <= lineOnes;
         end
      end
   end

   assign rxLineClock = phase_q[2];
   assign rxMfStart = (bit_q == 12'h000);
   assign rxCrcMfStart = (bit_q == 12'h000);
   // A stopped transmit clock stands low
   assign txLineClock = txRun & phase_q[2];
   assign txMfStart = (bit_q == 12'h000);
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "e1_alarm_params.svh"
module tb;
   import e1_alarm_pkg::*;
   logic clock, sys_rst, psel, penable, pwrite, rxInSync, rxSlip, txSlip, lineOnes, txRun;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic pready, pslverr, perr, rxLineClock, rxLineData, rxMfStart, rxCrcMfStart;
   logic txLineClock, txMfStart, txClockLossPin, irq;
   int bad_count, compares;
   localparam logic [11:0] AS = {2'b00, `IDX_ALARM_STATUS, 2'b00};
   localparam logic [11:0] ES = {2'b00, `IDX_EVENT_STATUS, 2'b00};
   localparam logic [11:0] AM = {2'b00, `IDX_ALARM_MASK, 2'b00};
   localparam logic [11:0] EM = {2'b00, `IDX_EVENT_MASK, 2'b00};
   localparam logic [11:0] CT = {2'b00, `IDX_CONTROL, 2'b00};

   e1_alarm_status #(.SEC_BITS(64), .SHORT_BITS(16)) e1_alarm_status_inst (
      .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxLineClock(rxLineClock), .rxLineData(rxLineData), .rxMfStart(rxMfStart),
      .rxCrcMfStart(rxCrcMfStart), .rxInSync(rxInSync), .rxSlip(rxSlip),
      .txLineClock(txLineClock), .txMfStart(txMfStart), .txSlip(txSlip),
      .txClockLossPin(txClockLossPin), .irq(irq));

   e1_line_model e1_line_model_inst (
      .clock(clock), .sys_rst(sys_rst), .lineOnes(lineOnes), .txRun(txRun),
      .rxLineClock(rxLineClock), .rxLineData(rxLineData), .rxMfStart(rxMfStart),
      .rxCrcMfStart(rxCrcMfStart), .txLineClock(txLineClock), .txMfStart(txMfStart));

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      perr = pslverr;
      if (n >= 20) begin
         bad_count++;
         final_report();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask

   // Poll the event status until bit b is seen set
   task automatic waitev(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, ES, 32'h0);
         n++;
      end while (rdata[b] !== 1'b1 && n < 400);
      if (n >= 400) begin
         bad_count++;
         final_report();
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (100000) @(posedge clock);
      bad_count++;
      final_report();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int m[$];
      sys_rst = 1'b1;
      {psel, penable, pwrite, rxInSync, rxSlip, txSlip, lineOnes} = 7'h00;
      txRun = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      void'($urandom(31));
      rdchk(AM, 32'h0);
      rdchk(EM, 32'h0);
      rdchk(CT, 32'h0);
      for (int i = 0; i < 4; i++) begin
         m.push_back($urandom & 255);
         apb(1'b1, AM, 32'(m[i]));
         apb(1'b1, EM, 32'(m[i] ^ 255));
         rdchk(AM, 32'(m[i]));
         rdchk(EM, 32'(m[i] ^ 255));
      end
      apb(1'b1, 12'h200, 32'hff);
      chk(perr, 1'b1);
      apb(1'b0, 12'h200, 32'h0);
      chk(perr, 1'b1);
      chk(rdata, 32'h0);
      apb(1'b1, AM, 32'h0);
      apb(1'b1, EM, 32'h0);
      $display("registers done");
      repeat (2400) @(posedge clock);
      rdchk(AS, 32'h03);
      rxInSync <= 1'b1;
      repeat (10) @(posedge clock);
      apb(1'b1, AS, 32'hff);
      rdchk(AS, 32'h02);
      $display("carrier loss done");
      apb(1'b1, ES, 32'hff);
      lineOnes <= 1'b1;
      repeat (8300 * 8) @(posedge clock);
      apb(1'b1, AS, 32'hff);
      rdchk(AS, 32'hcc);
      rdchk(ES, 32'hfa);
      $display("all ones done");
      chk(irq, 1'b0);
      apb(1'b1, AM, 32'h04);
      repeat (3) @(posedge clock);
      chk(irq, 1'b1);
      apb(1'b1, AM, 32'h21);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      apb(1'b1, AM, 32'h0);
      apb(1'b1, ES, 32'hff);
      txSlip <= 1'b1;
      rxSlip <= 1'b1;
      repeat (8) @(posedge clock);
      txSlip <= 1'b0;
      rxSlip <= 1'b0;
      apb(1'b0, ES, 32'h0);
      chk(rdata[0], 1'b1);
      apb(1'b0, AS, 32'h0);
      chk(rdata[4], 1'b1);
      apb(1'b1, EM, 32'h01);
      repeat (3) @(posedge clock);
      chk(irq, 1'b1);
      apb(1'b1, EM, 32'h0);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      $display("mask done");
      txRun <= 1'b0;
      repeat (60) @(posedge clock);
      apb(1'b0, ES, 32'h0);
      chk(rdata[2], 1'b1);
      chk(txClockLossPin, 1'b0);
      apb(1'b1, CT, 32'h08);
      repeat (3) @(posedge clock);
      chk(txClockLossPin, 1'b1);
      $display("clock loss done");
      // Tick period is 64 bits normally and 16 bits when short is selected
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, CT, 32'(s * 2));
         apb(1'b1, ES, 32'h10);
         waitev(4);
         apb(1'b1, ES, 32'h10);
         repeat (20 * 8) @(posedge clock);
         apb(1'b0, ES, 32'h0);
         chk(rdata[4], s[0]);
      end
      $display("second tick done");
      apb(1'b1, CT, 32'h04);
      lineOnes <= 1'b0;
      repeat (400 * 8) @(posedge clock);
      apb(1'b1, AS, 32'hff);
      apb(1'b0, AS, 32'h0);
      chk(rdata[1], 1'b0);
      repeat (1700 * 8) @(posedge clock);
      apb(1'b1, AS, 32'hff);
      apb(1'b0, AS, 32'h0);
      chk(rdata[3:1], 3'h1);
      $display("long threshold done");
      final_report();
   end
endmodule
